// *** design/rx_fifo.sv ***
`timescale 1ns/1ps
module rx_fifo (
  // clock and reset
  input wire logic    aclk,
  input wire logic    aresetn,
  // buffer port
  rx_fifo_if.store    fifo
);
  logic [serial_port_pkg::ENTRY_W-1:0] mem [serial_port_pkg::FIFO_DEPTH];
  logic [serial_port_pkg::PTR_W-1:0]   rd_ptr;
  logic [serial_port_pkg::PTR_W-1:0]   wr_ptr;
  logic [serial_port_pkg::CNT_W-1:0]   count;
  logic [serial_port_pkg::CNT_W-1:0]   next_count;
  wire                                 push_ok;
  wire                                 pop_ok;

  assign push_ok    = fifo.push && !fifo.full;
  assign pop_ok     = fifo.pop && !fifo.empty;
  assign next_count = count + serial_port_pkg::CNT_W'(push_ok)
                      - serial_port_pkg::CNT_W'(pop_ok);
  assign fifo.full  = (count == serial_port_pkg::CNT_W'(serial_port_pkg::FIFO_DEPTH));
  assign fifo.empty = (count == '0);
  assign fifo.head  = mem[rd_ptr];

  always_ff @(posedge aclk) begin
    if (!aresetn || fifo.flush) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (push_ok) begin
      mem[wr_ptr] <= fifo.push_data;
    end
  end
endmodule

// *** design/rx_fifo_if.sv ***
`timescale 1ns/1ps
interface rx_fifo_if;
  logic                                push;
  logic                                pop;
  logic                                flush;
  logic [serial_port_pkg::ENTRY_W-1:0] push_data;
  logic [serial_port_pkg::ENTRY_W-1:0] head;
  logic                                full;
  logic                                empty;
  modport owner (output push, pop, flush, push_data, input head, full, empty);
  modport store (input push, pop, flush, push_data, output head, full, empty);
endinterface

// *** design/serial_port_control_status.sv ***
`timescale 1ns/1ps
module serial_port_control_status (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  // axi4-lite write response
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  // axi4-lite read data
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // receive shift datapath
  input  wire logic        rx_char_valid,
  input  wire logic [8:0]  rx_char_data,
  input  wire logic        rx_char_frame_error,
  // transmit shift datapath
  output logic             tx_load,
  output logic      [8:0]  tx_char,
  output logic             tx_break,
  input  wire logic        tx_done,
  // configuration to datapath and pins
  output wire logic        rx_pin_owned,
  output wire logic        tx_pin_owned,
  output wire logic        receiver_enable,
  output wire logic        rx_nine_bit,
  output wire logic        tx_nine_bit,
  output wire logic        sync_mode,
  output wire logic        clock_master,
  output wire logic        high_speed_baud,
  // interrupt
  output wire logic        irq
);
  rx_fifo_if fifo ();

  rx_fifo u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fifo    (fifo.store)
  );

  localparam int IRQ_W   = serial_port_pkg::IRQ_W;
  localparam int IRQ_TOP = serial_port_pkg::IRQ_W - 1;

  // transmit control bits
  logic                   clock_source_select;
  logic                   transmit_nine_bit_select;
  logic                   transmit_enable_bit;
  logic                   sync_select;
  logic                   send_break_bit;
  logic                   high_speed_baud_select;
  logic                   transmit_ninth_bit;
  logic                   tx_busy;
  // receive control bits
  logic                   port_enable_bit;
  logic                   receive_width_select;
  logic                   single_receive_bit;
  logic                   continuous_receive_bit;
  logic                   address_detect_enable;
  logic                   overrun_error_flag;
  // interrupt registers
  logic [IRQ_TOP:0]       irq_status;
  logic [IRQ_TOP:0]       irq_mask;
  // write channel holding
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             wr_addr;
  logic [7:0]             wr_byte;
  logic                   wr_lane;

  // bus decode
  wire        wr_fire;
  wire        wr_hit;
  wire        wr_tx_ctrl;
  wire        wr_rx_ctrl;
  wire        wr_tx_data;
  wire        wr_irq_stat;
  wire        wr_irq_mask;
  wire        rd_fire;
  wire        rd_hit;
  wire        rd_pop;
  wire [7:0]  transmit_control_status;
  wire [7:0]  receive_control_status;
  wire [7:0]  rd_byte;
  // receive path
  wire        port_rst;
  wire        master_sync;
  wire        rx_on;
  wire        char_in;
  wire        addr_drop;
  wire        char_keep;
  wire        push_ok;
  wire        overrun_evt;
  wire        single_done;
  wire        cont_clear;
  wire        framing_error_flag;
  wire        received_ninth_bit;
  // transmit path
  wire        tx_allowed;
  wire        tx_start;
  wire        tx_finish;
  wire [IRQ_TOP:0] irq_events;
  wire [IRQ_TOP:0] irq_clear;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_hit  = (wr_addr == serial_port_pkg::ADDR_TX_CTRL)
                || (wr_addr == serial_port_pkg::ADDR_RX_CTRL)
                || (wr_addr == serial_port_pkg::ADDR_RX_DATA)
                || (wr_addr == serial_port_pkg::ADDR_TX_DATA)
                || (wr_addr == serial_port_pkg::ADDR_IRQ_STAT)
                || (wr_addr == serial_port_pkg::ADDR_IRQ_MASK);
  assign wr_tx_ctrl  = wr_fire && wr_lane && (wr_addr == serial_port_pkg::ADDR_TX_CTRL);
  assign wr_rx_ctrl  = wr_fire && wr_lane && (wr_addr == serial_port_pkg::ADDR_RX_CTRL);
  assign wr_tx_data  = wr_fire && wr_lane && (wr_addr == serial_port_pkg::ADDR_TX_DATA);
  assign wr_irq_stat = wr_fire && wr_lane && (wr_addr == serial_port_pkg::ADDR_IRQ_STAT);
  assign wr_irq_mask = wr_fire && wr_lane && (wr_addr == serial_port_pkg::ADDR_IRQ_MASK);
  assign rd_fire = arvalid && arready;
  assign rd_hit  = (araddr == serial_port_pkg::ADDR_TX_CTRL)
                || (araddr == serial_port_pkg::ADDR_RX_CTRL)
                || (araddr == serial_port_pkg::ADDR_RX_DATA)
                || (araddr == serial_port_pkg::ADDR_TX_DATA)
                || (araddr == serial_port_pkg::ADDR_IRQ_STAT)
                || (araddr == serial_port_pkg::ADDR_IRQ_MASK);
  // reading the data register advances the buffer
  assign rd_pop  = rd_fire && (araddr == serial_port_pkg::ADDR_RX_DATA);

  // RULE17: shift empty status
  assign transmit_control_status = {clock_source_select, transmit_nine_bit_select,
                                    transmit_enable_bit, sync_select, send_break_bit,
                                    high_speed_baud_select, !tx_busy, transmit_ninth_bit};
  assign receive_control_status  = {port_enable_bit, receive_width_select,
                                    single_receive_bit, continuous_receive_bit,
                                    address_detect_enable, framing_error_flag,
                                    overrun_error_flag, received_ninth_bit};
  assign rd_byte = (araddr == serial_port_pkg::ADDR_TX_CTRL)  ? transmit_control_status :
                   (araddr == serial_port_pkg::ADDR_RX_CTRL)  ? receive_control_status :
                   (araddr == serial_port_pkg::ADDR_RX_DATA)  ? fifo.head[7:0] :
                   (araddr == serial_port_pkg::ADDR_IRQ_STAT) ? 8'(irq_status) :
                   (araddr == serial_port_pkg::ADDR_IRQ_MASK) ? 8'(irq_mask) : 8'h00;

  // RULE2: disabled port held in reset
  assign port_rst    = !aresetn || !port_enable_bit;
  // RULE1: pins taken by the port
  assign rx_pin_owned = port_enable_bit;
  assign tx_pin_owned = port_enable_bit;
  assign master_sync  = sync_select && clock_source_select;
  // RULE5: single receive only as synchronous master
  // RULE6: continuous receive gates the receiver
  assign rx_on = port_enable_bit
              && (continuous_receive_bit || (master_sync && single_receive_bit));
  assign receiver_enable = rx_on;
  // RULE15: no reception during overrun
  assign char_in = rx_char_valid && rx_on && !overrun_error_flag;
  // RULE8: address filter in async nine-bit mode
  // RULE10: filter idle for eight-bit characters
  assign addr_drop = !sync_select && receive_width_select && address_detect_enable
                  && !rx_char_data[serial_port_pkg::ENT_NINTH];
  // RULE9: every character kept without filter
  assign char_keep   = char_in && !addr_drop;
  assign push_ok     = char_keep && !fifo.full;
  // RULE14: third character overruns
  assign overrun_evt = char_keep && fifo.full;
  // RULE7: continuous receive overrides single
  assign single_done = char_in && master_sync && !continuous_receive_bit;
  assign cont_clear  = wr_rx_ctrl && !wr_byte[serial_port_pkg::RX_CONT];

  assign fifo.push = push_ok;
  assign fifo.pop  = rd_pop;
  // RULE16: port disable empties buffer and framing flag
  assign fifo.flush = !port_enable_bit;
  // RULE3: ninth bit stored only for nine-bit width
  assign fifo.push_data = {rx_char_frame_error,
                           receive_width_select && rx_char_data[serial_port_pkg::ENT_NINTH],
                           rx_char_data[7:0]};
  // RULE11: framing flag of the head character
  assign framing_error_flag = !fifo.empty && fifo.head[serial_port_pkg::ENT_FRAME];
  // RULE13: ninth bit shown unchecked
  assign received_ninth_bit = !fifo.empty && fifo.head[serial_port_pkg::ENT_NINTH];

  assign rx_nine_bit     = receive_width_select;
  assign tx_nine_bit     = transmit_nine_bit_select;
  assign sync_mode       = sync_select;
  // RULE19: clock source only in synchronous mode
  assign clock_master    = master_sync;
  assign high_speed_baud = high_speed_baud_select;

  // receive enables override transmit in synchronous mode
  assign tx_allowed = port_enable_bit && transmit_enable_bit
                   && !(sync_select && (single_receive_bit || continuous_receive_bit));
  assign tx_start   = wr_tx_data && tx_allowed && !tx_busy;
  assign tx_finish  = tx_done && tx_busy;

  assign irq_events = IRQ_W'({tx_finish, overrun_evt, push_ok});
  assign irq_clear  = wr_irq_stat ? wr_byte[IRQ_TOP:0] : '0;
  assign irq        = |(irq_status & irq_mask);

  // write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= 8'h00;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= serial_port_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wr_byte <= wdata[7:0];
        wr_lane <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= serial_port_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_byte};
      rresp  <= rd_hit ? serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // RULE19: transmit control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_source_select      <= 1'b0;
      transmit_nine_bit_select <= 1'b0;
      transmit_enable_bit      <= 1'b0;
      sync_select              <= 1'b0;
      high_speed_baud_select   <= 1'b0;
      transmit_ninth_bit       <= 1'b0;
    end else if (wr_tx_ctrl) begin
      clock_source_select      <= wr_byte[serial_port_pkg::TX_CLK_SRC];
      transmit_nine_bit_select <= wr_byte[serial_port_pkg::TX_NINE];
      transmit_enable_bit      <= wr_byte[serial_port_pkg::TX_EN];
      sync_select              <= wr_byte[serial_port_pkg::TX_SYNC];
      high_speed_baud_select   <= wr_byte[serial_port_pkg::TX_BAUD_HI];
      transmit_ninth_bit       <= wr_byte[serial_port_pkg::TX_NINTH];
    end
  end

  // RULE18: break bit cleared when break completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      send_break_bit <= 1'b0;
    end else if (wr_tx_ctrl) begin
      send_break_bit <= wr_byte[serial_port_pkg::TX_BREAK];
    end else if (tx_finish && tx_break) begin
      send_break_bit <= 1'b0;
    end
  end

  // transmit handoff to shift register
  always_ff @(posedge aclk) begin
    if (port_rst) begin
      tx_busy  <= 1'b0;
      tx_load  <= 1'b0;
      tx_break <= 1'b0;
      tx_char  <= 9'h000;
    end else begin
      tx_load <= tx_start;
      if (tx_start) begin
        tx_busy  <= 1'b1;
        tx_break <= send_break_bit && !sync_select;
        tx_char  <= {transmit_nine_bit_select && transmit_ninth_bit, wr_byte};
      end else if (tx_finish) begin
        tx_busy  <= 1'b0;
        tx_break <= 1'b0;
      end
    end
  end

  // receive control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_enable_bit        <= 1'b0;
      receive_width_select   <= 1'b0;
      continuous_receive_bit <= 1'b0;
      address_detect_enable  <= 1'b0;
    end else if (wr_rx_ctrl) begin
      port_enable_bit        <= wr_byte[serial_port_pkg::RX_PORT_EN];
      receive_width_select   <= wr_byte[serial_port_pkg::RX_NINE];
      continuous_receive_bit <= wr_byte[serial_port_pkg::RX_CONT];
      address_detect_enable  <= wr_byte[serial_port_pkg::RX_ADDR_DET];
    end
  end

  // RULE4: single receive ends after one character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      single_receive_bit <= 1'b0;
    end else if (wr_rx_ctrl) begin
      single_receive_bit <= wr_byte[serial_port_pkg::RX_SINGLE];
    end else if (single_done) begin
      single_receive_bit <= 1'b0;
    end
  end

  // RULE12: overrun set wins over clear
  always_ff @(posedge aclk) begin
    if (port_rst) begin
      overrun_error_flag <= 1'b0;
    end else if (overrun_evt) begin
      overrun_error_flag <= 1'b1;
    end else if (cont_clear) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // sticky events, write one to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (wr_irq_mask) begin
        irq_mask <= wr_byte[IRQ_TOP:0];
      end
    end
  end

  property p_pins;
    @(posedge aclk) disable iff (!aresetn)
    wr_rx_ctrl |=> (rx_pin_owned == $past(wr_byte[serial_port_pkg::RX_PORT_EN]));
  endproperty
  a_pins: assert property (p_pins) else $error("pins not taken by port enable"); // RULE1

  property p_port_reset;
    @(posedge aclk) disable iff (!aresetn)
    !port_enable_bit |=> fifo.empty && !overrun_error_flag && !tx_busy;
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("disabled port not reset"); // RULE2

  property p_single;
    @(posedge aclk) disable iff (!aresetn)
    single_done && !wr_rx_ctrl |=> !single_receive_bit;
  endproperty
  a_single: assert property (p_single) else $error("single receive not cleared"); // RULE4

  property p_addr;
    @(posedge aclk) disable iff (!aresetn)
    rx_char_valid && !sync_select && receive_width_select && address_detect_enable
      && !rx_char_data[serial_port_pkg::ENT_NINTH] |-> !fifo.push;
  endproperty
  a_addr: assert property (p_addr) else $error("non-address character accepted"); // RULE8

  property p_overrun_clear;
    @(posedge aclk) disable iff (!aresetn)
    overrun_error_flag && cont_clear && !overrun_evt |=> !overrun_error_flag;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun stuck"); // RULE12

  property p_third;
    @(posedge aclk) disable iff (!aresetn)
    port_enable_bit && fifo.full && char_keep |=> overrun_error_flag ##1 overrun_error_flag || $past(cont_clear);
  endproperty
  a_third: assert property (p_third) else $error("third character lost silently"); // RULE14

  property p_hold_off;
    @(posedge aclk) disable iff (!aresetn)
    overrun_error_flag |-> !fifo.push;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("receive during overrun"); // RULE15

  property p_busy;
    @(posedge aclk) disable iff (!aresetn)
    tx_start |=> tx_load && !transmit_control_status[serial_port_pkg::TX_EMPTY];
  endproperty
  a_busy: assert property (p_busy) else $error("shift empty after load"); // RULE17

  property p_break;
    @(posedge aclk) disable iff (!aresetn)
    tx_finish && tx_break && !wr_tx_ctrl |=> !send_break_bit;
  endproperty
  a_break: assert property (p_break) else $error("break bit not cleared"); // RULE18
endmodule

// *** design/serial_port_pkg.sv ***
// Functional notes
// RULE1: port enable set hands receive and transmit pins to the serial port.
// RULE2: port enable clear holds all receive and transmit state in reset.
// RULE3: receive width bit selects nine-bit characters when set, eight when clear.
// RULE4: synchronous master single-receive takes one character, then hardware clears it.
// RULE5: single-receive does nothing in asynchronous or synchronous slave mode; the design still lets it block transmit in synchronous slave mode.
// RULE6: asynchronous mode: continuous-receive enables the receiver when set.
// RULE7: synchronous mode: continuous-receive runs until cleared, overriding single-receive.
// RULE8: async nine-bit address detect keeps only characters whose bit 8 is one.
// RULE9: address detect off keeps every character, ninth bit passed through unchanged.
// RULE10: address detect has no effect in eight-bit asynchronous reception.
// RULE11: read-only framing flag follows the head character, advancing on reads.
// RULE12: read-only overrun flag set on overflow, cleared by clearing continuous-receive.
// RULE13: ninth received bit shown unchecked in a status bit.
// RULE14: buffer holds two characters; a third complete one raises overrun.
// RULE15: while overrun is set nothing is received; buffered characters stay readable.
// RULE16: port disable clears framing flag; clearing continuous-receive leaves it alone.
// RULE17: shift-empty status reads one when idle, zero while sending, one after reset.
// RULE18: async send-break sends a break next transmission, cleared when it completes.
// RULE19: transmit control bits are read/write, reset zero; clock source only synchronous.
package serial_port_pkg;
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 32;
  localparam int         REG_W         = 8;
  localparam int         CHAR_W        = 9;
  localparam int         ENTRY_W       = 10;
  localparam int         FIFO_DEPTH    = 2;
  localparam int         PTR_W         = 1;
  localparam int         CNT_W         = 2;
  localparam int         IRQ_W         = 3;
  localparam logic [7:0] ADDR_TX_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_RX_DATA  = 8'h08;
  localparam logic [7:0] ADDR_TX_DATA  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam int         TX_CLK_SRC    = 7;
  localparam int         TX_NINE       = 6;
  localparam int         TX_EN         = 5;
  localparam int         TX_SYNC       = 4;
  localparam int         TX_BREAK      = 3;
  localparam int         TX_BAUD_HI    = 2;
  localparam int         TX_EMPTY      = 1;
  localparam int         TX_NINTH      = 0;
  localparam int         RX_PORT_EN    = 7;
  localparam int         RX_NINE       = 6;
  localparam int         RX_SINGLE     = 5;
  localparam int         RX_CONT       = 4;
  localparam int         RX_ADDR_DET   = 3;
  localparam int         RX_FRAME_ERR  = 2;
  localparam int         RX_OVERRUN    = 1;
  localparam int         RX_NINTH      = 0;
  localparam int         ENT_FRAME     = 9;
  localparam int         ENT_NINTH     = 8;
  localparam int         IRQ_RX        = 0;
  localparam int         IRQ_OVR       = 1;
  localparam int         IRQ_TX        = 2;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_DECERR   = 2'h3;
endpackage

// *** testbench/serial_far_end.sv ***
`timescale 1ns/1ps
module serial_far_end (
  // clock
  input  wire logic       aclk,
  // transmit side
  input  wire logic       tx_load,
  output logic            tx_done,
  // receive side
  output logic            rx_char_valid,
  output logic      [8:0] rx_char_data,
  output logic            rx_char_frame_error
);
  logic [3:0] busy_cnt = 4'h0;
  initial begin
    tx_done = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 9'h000;
    rx_char_frame_error = 1'b0;
  end
  // one whole character; between frames the lines show no stale value
  task automatic send(input logic [8:0] d, input logic fe);
    @(posedge aclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    rx_char_frame_error <= fe;
    @(posedge aclk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~d;
    rx_char_frame_error <= ~fe;
  endtask
  // finishes a loaded character a few cycles later
  always @(posedge aclk) begin
    tx_done <= (busy_cnt == 4'h1);
    if (tx_load) busy_cnt <= 4'h6;
    else if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, b1, b2;
  logic [31:0] wdata = 32'h0000_0000, r = 32'h9103;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1;
  logic [3:0]  wstrb = 4'h1;
  logic [33:0] q[$], note;
  int          fails = 0, checks = 0, cycles = 0;
  wire logic   awready, wready, bvalid, arready, rvalid, tx_load, tx_break, tx_done, irq;
  wire logic   rx_char_valid, rx_char_frame_error, rx_pin_owned, receiver_enable;
  wire logic   tx_pin_owned, rx_nine_bit, tx_nine_bit, sync_mode, clock_master, high_speed_baud;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [8:0]  rx_char_data, tx_char;
  always #2 aclk = ~aclk;
  serial_port_control_status dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .rx_char_valid, .rx_char_data, .rx_char_frame_error,
    .tx_load, .tx_char, .tx_break, .tx_done, .rx_pin_owned, .tx_pin_owned,
    .receiver_enable, .rx_nine_bit, .tx_nine_bit, .sync_mode, .clock_master,
    .high_speed_baud, .irq);
  serial_far_end far (.aclk, .tx_load, .tx_done, .rx_char_valid, .rx_char_data,
    .rx_char_frame_error);
  function automatic logic [7:0] rnd();
    r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r[7:0];
  endfunction
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", 1'b1, bresp === serial_port_pkg::RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] rs = serial_port_pkg::RESP_OKAY);
    q.push_back({rs, 24'h00_0000, e});
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      note = q.pop_front();
      checks++;
      if ({rresp, rdata} !== note) begin
        fails++;
        $display("unexpected read expected %h seen %h", note, {rresp, rdata});
      end
    end
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 8'h02);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'hd0);
    chk("rx_pin_owned", 1'b1, rx_pin_owned);
    chk("tx_pin_owned", 1'b1, tx_pin_owned);
    chk("rx_nine_bit", 1'b1, rx_nine_bit);
    chk("high_speed_baud", 1'b0, high_speed_baud);
    chk("tx_nine_bit", 1'b0, tx_nine_bit);
    b1 = rnd();
    b2 = rnd();
    far.send({1'b1, b1}, 1'b1);
    far.send({1'b0, b2}, 1'b0);
    far.send({1'b1, rnd()}, 1'b0);
    rd(8'h04, 8'hd7);
    rd(8'h08, b1);
    rd(8'h04, 8'hd2);
    far.send(9'h155, 1'b1);
    rd(8'h08, b2);
    rd(8'h04, 8'hd2);
    wr(8'h04, 8'hc0);
    rd(8'h04, 8'hc0);
    wr(8'h04, 8'hd8);
    far.send({1'b0, rnd()}, 1'b0);
    b1 = rnd();
    far.send({1'b1, b1}, 1'b0);
    rd(8'h04, 8'hd9);
    rd(8'h08, b1);
    wr(8'h04, 8'h98);
    b1 = rnd();
    far.send({1'b0, b1}, 1'b0);
    rd(8'h08, b1);
    chk("irq", 1'b0, irq);
    wr(8'h14, 8'h01);
    chk("irq", 1'b1, irq);
    wr(8'h10, 8'h07);
    chk("irq", 1'b0, irq);
    wr(8'h04, 8'hd0);
    far.send(9'h0aa, 1'b1);
    wr(8'h04, 8'hc0);
    rd(8'h04, 8'hc4);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00);
    chk("rx_pin_owned", 1'b0, rx_pin_owned);
    wr(8'h00, 8'h90);
    wr(8'h04, 8'ha0);
    chk("receiver_enable", 1'b1, receiver_enable);
    chk("sync_mode", 1'b1, sync_mode);
    chk("clock_master", 1'b1, clock_master);
    far.send(9'h033, 1'b0);
    rd(8'h04, 8'h80);
    wr(8'h04, 8'hb0);
    far.send(9'h034, 1'b0);
    rd(8'h04, 8'hb0);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'ha0);
    chk("receiver_enable", 1'b0, receiver_enable);
    chk("clock_master", 1'b0, clock_master);
    wr(8'h00, 8'h28);
    rd(8'h00, 8'h2a);
    b1 = rnd();
    wr(8'h0c, b1);
    @(negedge aclk);
    chk("tx_break", 1'b1, tx_break);
    chk("tx_char", 1'b1, tx_char === {1'b0, b1});
    for (int i = 0; i < 40 && tx_done !== 1'b1; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    rd(8'h00, 8'h22);
    rd(8'h20, 8'h00, serial_port_pkg::RESP_DECERR);
    repeat (2) @(posedge aclk);
    end_sim();
  end
endmodule
